// File: logic/aogt_pkg.sv
/*
 * shared constants for the converter trim register bank.
 * assumes byte addresses on a 10-bit plain register port, 16-bit data.
 */
package aogt_pkg;
   // ----------------------------------------
   // bus shape
   // ----------------------------------------
   localparam int ADDR_W = 10;
   localparam int DATA_W = 16;
   localparam int OFS_W = 12;
   localparam int GAIN_W = 5;
   // ----------------------------------------
   // trim storage entries
   // ----------------------------------------
   localparam int NUM_TRIMS = 9;
   localparam int IDX_W = 4;
   localparam logic [3:0] IDX_C2A_OFS = 4'h0;
   localparam logic [3:0] IDX_C2B_OFS = 4'h1;
   localparam logic [3:0] IDX_C3C_OFS = 4'h2;
   localparam logic [3:0] IDX_C3D_OFS = 4'h3;
   localparam logic [3:0] IDX_C4_OFS = 4'h4;
   localparam logic [3:0] IDX_C5_OFS = 4'h5;
   localparam logic [3:0] IDX_C0_GAIN = 4'h6;
   localparam logic [3:0] IDX_C1_GAIN = 4'h7;
   localparam logic [3:0] IDX_C2A_GAIN = 4'h8;
   localparam logic [3:0] IDX_NONE = 4'hF;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [9:0] CORE2_INPUTA_OFFSET_TRIM = 10'h334;
   localparam logic [9:0] CORE2_INPUTB_OFFSET_TRIM = 10'h336;
   localparam logic [9:0] CORE3_INPUTC_OFFSET_TRIM = 10'h338;
   localparam logic [9:0] CORE3_INPUTD_OFFSET_TRIM = 10'h33A;
   localparam logic [9:0] CORE4_OFFSET_TRIM = 10'h33C;
   localparam logic [9:0] CORE5_OFFSET_TRIM = 10'h33E;
   localparam logic [9:0] CORE0_FINE_GAIN_TRIM = 10'h360;
   localparam logic [9:0] CORE1_FINE_GAIN_TRIM = 10'h361;
   localparam logic [9:0] CORE2_INPUTA_FINE_GAIN_TRIM = 10'h362;
   localparam logic [9:0] TRIM_STATUS = 10'h3F0;
   localparam logic [9:0] TRIM_CONTROL = 10'h3F2;
   // ----------------------------------------
   // fields and reset values
   // ----------------------------------------
   localparam logic [15:0] OFS_REG_MASK = 16'hFFFF;
   localparam logic [15:0] GAIN_REG_MASK = 16'h00FF;
   localparam logic [15:0] TRIM_RESET = 16'h0000;
   localparam int STAT_FUSE_DONE = 0;
   localparam int STAT_CAL_CLASH = 1;
   localparam int CTRL_RELOAD = 0;
endpackage : aogt_pkg

// File: logic/aogt_fuse_loader.sv
/*
 * walks the fuse storage once after reset or on request and hands each
 * default word to the trim bank.
 * assumes fuse storage on the same clock answers one cycle after a read.
 */
`timescale 1ns/1ns
module aogt_fuse_loader #(
   parameter int NUM = aogt_pkg::NUM_TRIMS
) (
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_start,
   output logic [aogt_pkg::IDX_W-1:0] o_fuse_addr,
   output logic o_fuse_rd,
   input wire logic [aogt_pkg::DATA_W-1:0] i_fuse_data,
   output logic o_load_we,
   output logic [aogt_pkg::IDX_W-1:0] o_load_idx,
   output logic [aogt_pkg::DATA_W-1:0] o_load_data,
   output logic o_done
);
   typedef enum logic [0:0] {ST_IDLE, ST_WALK} aogt_load_state_type;
   aogt_load_state_type state;
   logic pending;
   logic rd_q;
   logic [aogt_pkg::IDX_W-1:0] addr_q;
   logic [aogt_pkg::IDX_W-1:0] last_idx;

   // the first walk starts by itself once reset is released
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         pending <= 1'b1;
      end else if (state == ST_IDLE) begin
         pending <= i_start;
      end else if (i_start) begin
         pending <= 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         state <= ST_IDLE;
         o_fuse_addr <= '0;
         o_fuse_rd <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               o_fuse_rd <= pending;
               o_fuse_addr <= '0;
               if (pending) begin
                  state <= ST_WALK;
               end
            end
            ST_WALK: begin
               if (o_fuse_addr == aogt_pkg::IDX_W'(NUM - 1)) begin
                  o_fuse_rd <= 1'b0;
                  state <= ST_IDLE;
               end else begin
                  o_fuse_addr <= o_fuse_addr + 1'b1;
               end
            end
         endcase
      end
   end

   // the fuse word answers a cycle after its strobe, so strobe and index
   // wait one stage to meet their own data
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         rd_q <= 1'b0;
         addr_q <= '0;
         o_load_we <= 1'b0;
         o_load_idx <= '0;
         o_load_data <= '0;
         last_idx <= '0;
      end else begin
         rd_q <= o_fuse_rd;
         addr_q <= o_fuse_addr;
         o_load_we <= rd_q;
         o_load_idx <= addr_q;
         last_idx <= addr_q;
         o_load_data <= i_fuse_data;
      end
   end

   // done stays low during a walk and rises on the same edge that writes the last entry
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_done <= 1'b0;
      end else if (pending || o_fuse_rd) begin
         o_done <= 1'b0;
      end else if (o_load_we && last_idx == aogt_pkg::IDX_W'(NUM - 1)) begin
         o_done <= 1'b1;
      end
   end
endmodule : aogt_fuse_loader

// File: logic/aogt_trim_select.sv
/*
 * picks the offset trim cores 2 and 3 apply from the input pair each samples.
 * assumes the pair selects come from logic on the same clock.
 */
`timescale 1ns/1ns
module aogt_trim_select (
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_core2_sel_b,
   input wire logic i_core3_sel_d,
   input wire logic [11:0] i_pair_a_trim,
   input wire logic [11:0] i_pair_b_trim,
   input wire logic [11:0] i_pair_c_trim,
   input wire logic [11:0] i_pair_d_trim,
   output logic [11:0] o_core2_offset,
   output logic [11:0] o_core3_offset
);
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_core2_offset <= '0;
      end else if (i_core2_sel_b) begin
         o_core2_offset <= i_pair_b_trim;
      end else begin
         o_core2_offset <= i_pair_a_trim;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_core3_offset <= '0;
      end else begin
         o_core3_offset <= i_core3_sel_d ? i_pair_d_trim : i_pair_c_trim;
      end
   end
endmodule : aogt_trim_select

// File: logic/aogt_trim_regs.sv
/*
 * trim register bank: offset and fine gain corrections per converter core,
 * loaded from fuse storage and then open to software on a plain port.
 * assumes a single-cycle master on the same clock and fuse storage
 * that answers one cycle after its read strobe.
 */
`timescale 1ns/1ns

module aogt_trim_regs #(
   parameter int NUM = aogt_pkg::NUM_TRIMS
) (
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic [aogt_pkg::ADDR_W-1:0] i_addr,
   input wire logic [aogt_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [aogt_pkg::DATA_W-1:0] o_rdata,
   output logic [aogt_pkg::IDX_W-1:0] o_fuse_addr,
   output logic o_fuse_rd,
   input wire logic [aogt_pkg::DATA_W-1:0] i_fuse_data,
   input wire logic i_offset_cal_busy,
   input wire logic i_core2_sel_b,
   input wire logic i_core3_sel_d,
   output logic [aogt_pkg::OFS_W-1:0] o_core2_offset,
   output logic [aogt_pkg::OFS_W-1:0] o_core3_offset,
   output logic [aogt_pkg::OFS_W-1:0] o_core4_offset,
   output logic [aogt_pkg::OFS_W-1:0] o_core5_offset,
   output logic [aogt_pkg::GAIN_W-1:0] o_core0_gain,
   output logic [aogt_pkg::GAIN_W-1:0] o_core1_gain,
   output logic [aogt_pkg::GAIN_W-1:0] o_core2_gain,
   output logic o_fuse_done
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [aogt_pkg::DATA_W-1:0] trim [NUM];
   logic [aogt_pkg::IDX_W-1:0] wr_idx;
   logic [aogt_pkg::IDX_W-1:0] rd_idx;
   logic wr_hit;
   logic rd_hit;
   logic wr_is_ofs;
   logic rd_is_ofs;
   logic load_we;
   logic [aogt_pkg::IDX_W-1:0] load_idx;
   logic [aogt_pkg::DATA_W-1:0] load_data;
   logic fuse_done;
   logic reload;
   logic cal_clash;
   logic next_cal_clash;
   logic [aogt_pkg::DATA_W-1:0] next_rdata;
   logic [aogt_pkg::DATA_W-1:0] status_word;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   function automatic logic [aogt_pkg::IDX_W-1:0] trim_index(
      input logic [aogt_pkg::ADDR_W-1:0] addr
   );
      logic [aogt_pkg::IDX_W-1:0] idx;
      idx = aogt_pkg::IDX_NONE;
      unique case (addr)
         aogt_pkg::CORE2_INPUTA_OFFSET_TRIM: idx = aogt_pkg::IDX_C2A_OFS;
         aogt_pkg::CORE2_INPUTB_OFFSET_TRIM: idx = aogt_pkg::IDX_C2B_OFS;
         aogt_pkg::CORE3_INPUTC_OFFSET_TRIM: idx = aogt_pkg::IDX_C3C_OFS;
         aogt_pkg::CORE3_INPUTD_OFFSET_TRIM: idx = aogt_pkg::IDX_C3D_OFS;
         aogt_pkg::CORE4_OFFSET_TRIM: idx = aogt_pkg::IDX_C4_OFS;
         aogt_pkg::CORE5_OFFSET_TRIM: idx = aogt_pkg::IDX_C5_OFS;
         aogt_pkg::CORE0_FINE_GAIN_TRIM: idx = aogt_pkg::IDX_C0_GAIN;
         aogt_pkg::CORE1_FINE_GAIN_TRIM: idx = aogt_pkg::IDX_C1_GAIN;
         aogt_pkg::CORE2_INPUTA_FINE_GAIN_TRIM: idx = aogt_pkg::IDX_C2A_GAIN;
         default: idx = aogt_pkg::IDX_NONE;
      endcase
      return idx;
   endfunction : trim_index

   // offset entries sit below the gain entries in the index space
   function automatic logic index_is_offset(
      input logic [aogt_pkg::IDX_W-1:0] idx
   );
      return idx <= aogt_pkg::IDX_C5_OFS;
   endfunction : index_is_offset

   function automatic logic [aogt_pkg::DATA_W-1:0] entry_mask(
      input logic [aogt_pkg::IDX_W-1:0] idx
   );
      logic [aogt_pkg::DATA_W-1:0] mask;
      mask = aogt_pkg::GAIN_REG_MASK;
      if (index_is_offset(idx)) begin
         mask = aogt_pkg::OFS_REG_MASK;
      end
      return mask;
   endfunction : entry_mask

   always_comb begin
      wr_idx = trim_index(i_addr);
      rd_idx = trim_index(i_addr);
      wr_hit = i_wr && (wr_idx != aogt_pkg::IDX_NONE);
      rd_hit = i_rd && (rd_idx != aogt_pkg::IDX_NONE);
      wr_is_ofs = wr_hit && index_is_offset(wr_idx);
      rd_is_ofs = rd_hit && index_is_offset(rd_idx);
   end

   // ----------------------------------------
   // fuse default loading
   // ----------------------------------------
   aogt_fuse_loader #(
      .NUM(NUM)
   ) u_fuse_loader (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_start(reload),
      .o_fuse_addr(o_fuse_addr),
      .o_fuse_rd(o_fuse_rd),
      .i_fuse_data(i_fuse_data),
      .o_load_we(load_we),
      .o_load_idx(load_idx),
      .o_load_data(load_data),
      .o_done(fuse_done)
   );

   assign o_fuse_done = fuse_done;

   // ----------------------------------------
   // trim storage
   // ----------------------------------------
   // a software write in the same cycle as a fuse load of the same entry
   // wins: the load is the older value and software is the later intent.
   // offset reserved bits are stored as written; gain entries keep only the low byte of a write.
   genvar g;
   generate
      for (g = 0; g < NUM; g++) begin : g_trim
         localparam logic [aogt_pkg::IDX_W-1:0] ME = aogt_pkg::IDX_W'(g);
         always_ff @(posedge i_core_clk or posedge i_reset) begin
            if (i_reset) begin
               trim[g] <= aogt_pkg::TRIM_RESET;
            end else if (wr_hit && wr_idx == ME) begin
               trim[g] <= i_wdata & entry_mask(ME);
            end else if (load_we && load_idx == ME) begin
               trim[g] <= load_data & entry_mask(ME);
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // control and status
   // ----------------------------------------
   // reload is a one-cycle request; the loader holds it until it is free
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         reload <= 1'b0;
      end else begin
         reload <= i_wr && (i_addr == aogt_pkg::TRIM_CONTROL)
                   && i_wdata[aogt_pkg::CTRL_RELOAD];
      end
   end

   // sticky record of an offset trim touched while offset calibration runs;
   // the hardware cannot block it, so it only reports it. set wins over clear.
   always_comb begin
      next_cal_clash = cal_clash;
      if (i_wr && (i_addr == aogt_pkg::TRIM_STATUS)
          && i_wdata[aogt_pkg::STAT_CAL_CLASH]) begin
         next_cal_clash = 1'b0;
      end
      if (i_offset_cal_busy && (wr_is_ofs || rd_is_ofs)) begin
         next_cal_clash = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         cal_clash <= 1'b0;
      end else begin
         cal_clash <= next_cal_clash;
      end
   end

   always_comb begin
      status_word = '0;
      status_word[aogt_pkg::STAT_FUSE_DONE] = fuse_done;
      status_word[aogt_pkg::STAT_CAL_CLASH] = cal_clash;
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   // data stands only in the cycle after the strobe; unmapped reads give zero
   always_comb begin
      next_rdata = '0;
      if (rd_hit) begin
         next_rdata = trim[rd_idx];
      end else if (i_rd && i_addr == aogt_pkg::TRIM_STATUS) begin
         next_rdata = status_word;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // per-core trims
   // ----------------------------------------
   // only the low 12 bits reach the cores; a stray reserved bit written
   // against the software contract cannot disturb the correction
   aogt_trim_select u_trim_select (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_core2_sel_b(i_core2_sel_b),
      .i_core3_sel_d(i_core3_sel_d),
      .i_pair_a_trim(trim[aogt_pkg::IDX_C2A_OFS][aogt_pkg::OFS_W-1:0]),
      .i_pair_b_trim(trim[aogt_pkg::IDX_C2B_OFS][aogt_pkg::OFS_W-1:0]),
      .i_pair_c_trim(trim[aogt_pkg::IDX_C3C_OFS][aogt_pkg::OFS_W-1:0]),
      .i_pair_d_trim(trim[aogt_pkg::IDX_C3D_OFS][aogt_pkg::OFS_W-1:0]),
      .o_core2_offset(o_core2_offset),
      .o_core3_offset(o_core3_offset)
   );

   // offsets travel as plain unsigned codes, no sign extension anywhere
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_core4_offset <= '0;
      end else begin
         o_core4_offset <= trim[aogt_pkg::IDX_C4_OFS][aogt_pkg::OFS_W-1:0];
      end
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_core5_offset <= '0;
      end else begin
         o_core5_offset <= trim[aogt_pkg::IDX_C5_OFS][aogt_pkg::OFS_W-1:0];
      end
   end

   // gain fields drop the reserved top bits of each byte
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_core0_gain <= '0;
      end else begin
         o_core0_gain <= trim[aogt_pkg::IDX_C0_GAIN][aogt_pkg::GAIN_W-1:0];
      end
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_core1_gain <= '0;
      end else begin
         o_core1_gain <= trim[aogt_pkg::IDX_C1_GAIN][aogt_pkg::GAIN_W-1:0];
      end
   end

   // only the pair A gain is held here; the pair B gain lives elsewhere
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_core2_gain <= '0;
      end else if (!i_core2_sel_b) begin
         o_core2_gain <= trim[aogt_pkg::IDX_C2A_GAIN][aogt_pkg::GAIN_W-1:0];
      end
   end
endmodule : aogt_trim_regs

// File: testbench/aogt_trim_regs_chk.sv
/*
 * concurrent checks on the trim register bank ports.
 * assumes one clock, async active-high reset; writes are judged only
 * once a fuse walk has finished, since a walk overwrites entries.
 */
`timescale 1ns/1ns
module aogt_trim_regs_chk (
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic [aogt_pkg::ADDR_W-1:0] i_addr,
   input wire logic [aogt_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [aogt_pkg::DATA_W-1:0] o_rdata,
   input wire logic [aogt_pkg::IDX_W-1:0] o_fuse_addr,
   input wire logic o_fuse_rd,
   input wire logic i_core2_sel_b,
   input wire logic [aogt_pkg::OFS_W-1:0] o_core4_offset,
   input wire logic [aogt_pkg::OFS_W-1:0] o_core5_offset,
   input wire logic [aogt_pkg::GAIN_W-1:0] o_core0_gain,
   input wire logic [aogt_pkg::GAIN_W-1:0] o_core1_gain,
   input wire logic [aogt_pkg::GAIN_W-1:0] o_core2_gain,
   input wire logic o_fuse_done
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   // ----------------------------------------
   // write to core output
   // ----------------------------------------
   // guarded by fuse done: a load may still overwrite an entry during the walk
   property write_lands(logic [9:0] a, logic [15:0] m, logic [15:0] q);
      $past(i_wr, 2) && ($past(i_addr, 2) == a) && $past(o_fuse_done, 2)
         |-> q == ($past(i_wdata, 2) & m);
   endproperty
   core4_write_a: assert property (write_lands(aogt_pkg::CORE4_OFFSET_TRIM, 16'h0FFF, {4'h0, o_core4_offset}))
      else $error("core 4 offset does not follow write");
   core5_write_a: assert property (write_lands(aogt_pkg::CORE5_OFFSET_TRIM, 16'h0FFF, {4'h0, o_core5_offset}))
      else $error("core 5 offset does not follow write");
   core0_fine_gain_trim_write_a: assert property (write_lands(aogt_pkg::CORE0_FINE_GAIN_TRIM, 16'h001F, {11'h000, o_core0_gain}))
      else $error("core 0 gain does not follow write");
   core1_fine_gain_trim_write_a: assert property (write_lands(aogt_pkg::CORE1_FINE_GAIN_TRIM, 16'h001F, {11'h000, o_core1_gain}))
      else $error("core 1 gain does not follow write");
   // ----------------------------------------
   // read port and gain selection
   // ----------------------------------------
   rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("read data present without a read");
   gain2_freeze_a: assert property ($past(i_core2_sel_b) && $past(i_core2_sel_b, 2) |-> $stable(o_core2_gain))
      else $error("core 2 gain moved while pair B selected");
   // ----------------------------------------
   // fuse walk
   // ----------------------------------------
   fuse_walk_len_a: assert property ($rose(o_fuse_rd) |-> o_fuse_addr == 4'h0 ##1 o_fuse_rd[*8] ##1 !o_fuse_rd)
      else $error("fuse walk length wrong");
   fuse_addr_step_a: assert property (o_fuse_rd && $past(o_fuse_rd) |-> o_fuse_addr == $past(o_fuse_addr) + 4'h1)
      else $error("fuse index does not step by one");
   fuse_done_a: assert property ($fell(o_fuse_rd) |-> ##[1:3] o_fuse_done)
      else $error("fuse done not raised after walk");
   cov_write_c: cover property (i_wr && i_addr == aogt_pkg::CORE4_OFFSET_TRIM);
   cov_read_c: cover property (i_rd ##1 o_rdata != 16'h0000);
   cov_sel_c: cover property ($rose(i_core2_sel_b));
endmodule : aogt_trim_regs_chk

bind aogt_trim_regs aogt_trim_regs_chk u_chk (.i_core_clk(i_core_clk), .i_reset(i_reset),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_fuse_addr(o_fuse_addr), .o_fuse_rd(o_fuse_rd), .i_core2_sel_b(i_core2_sel_b),
   .o_core4_offset(o_core4_offset), .o_core5_offset(o_core5_offset),
   .o_core0_gain(o_core0_gain), .o_core1_gain(o_core1_gain), .o_core2_gain(o_core2_gain),
   .o_fuse_done(o_fuse_done));

// File: testbench/tb_top.sv
/*
 * self-checking bench for the trim register bank: fuse defaults, random
 * writes and reads, input pair selection, status on calibration clash.
 * assumes the design answers reads one cycle later and walks fuses alone.
 */
`timescale 1ns/1ns
module tb_top;
   logic i_core_clk = 1'b0;
   logic i_reset = 1'b1;
   logic [9:0] i_addr = 10'h000;
   logic [15:0] i_wdata = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [15:0] i_fuse_data = 16'h0000;
   logic i_offset_cal_busy = 1'b0;
   logic i_core2_sel_b = 1'b0;
   logic i_core3_sel_d = 1'b0;
   logic [15:0] o_rdata;
   logic [3:0] o_fuse_addr;
   logic o_fuse_rd;
   logic [11:0] o_core2_offset, o_core3_offset, o_core4_offset, o_core5_offset;
   logic [4:0] o_core0_gain, o_core1_gain, o_core2_gain;
   logic o_fuse_done;
   int error_cnt = 0;
   int comparisons = 0;
   logic [15:0] fuse_rom [0:8];
   logic [15:0] exp_reg [0:8];
   logic [9:0] reg_addr [0:8] = '{aogt_pkg::CORE2_INPUTA_OFFSET_TRIM,
      aogt_pkg::CORE2_INPUTB_OFFSET_TRIM, aogt_pkg::CORE3_INPUTC_OFFSET_TRIM,
      aogt_pkg::CORE3_INPUTD_OFFSET_TRIM, aogt_pkg::CORE4_OFFSET_TRIM,
      aogt_pkg::CORE5_OFFSET_TRIM, aogt_pkg::CORE0_FINE_GAIN_TRIM,
      aogt_pkg::CORE1_FINE_GAIN_TRIM, aogt_pkg::CORE2_INPUTA_FINE_GAIN_TRIM};

   aogt_trim_regs dut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_fuse_addr(o_fuse_addr), .o_fuse_rd(o_fuse_rd), .i_fuse_data(i_fuse_data),
      .i_offset_cal_busy(i_offset_cal_busy), .i_core2_sel_b(i_core2_sel_b),
      .i_core3_sel_d(i_core3_sel_d), .o_core2_offset(o_core2_offset),
      .o_core3_offset(o_core3_offset), .o_core4_offset(o_core4_offset),
      .o_core5_offset(o_core5_offset), .o_core0_gain(o_core0_gain),
      .o_core1_gain(o_core1_gain), .o_core2_gain(o_core2_gain), .o_fuse_done(o_fuse_done));

   // ----------------------------------------
   // clock and fuse storage
   // ----------------------------------------
   initial begin
      forever #4 i_core_clk = ~i_core_clk;
   end
   // fuse word answers one cycle after its strobe; between strobes it shows junk
   always @(posedge i_core_clk) begin
      i_fuse_data <= o_fuse_rd ? fuse_rom[o_fuse_addr] : ~i_fuse_data;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [15:0] mask_of(input int i);
      return (i < 6) ? aogt_pkg::OFS_REG_MASK : aogt_pkg::GAIN_REG_MASK;
   endfunction : mask_of

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask : chk

   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      @(posedge i_core_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [9:0] a, input logic [15:0] exp);
      @(posedge i_core_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1 chk(o_rdata, exp);
   endtask : rd_chk

   // selects settle one cycle, writes two: four edges leaves margin
   task automatic cores_chk();
      repeat (4) @(posedge i_core_clk);
      #1;
      chk({4'h0, o_core2_offset}, exp_reg[i_core2_sel_b ? 1 : 0] & 16'h0FFF);
      chk({4'h0, o_core3_offset}, exp_reg[i_core3_sel_d ? 3 : 2] & 16'h0FFF);
      chk({4'h0, o_core4_offset}, exp_reg[4] & 16'h0FFF);
      chk({4'h0, o_core5_offset}, exp_reg[5] & 16'h0FFF);
      chk({11'h0, o_core0_gain}, exp_reg[6] & 16'h001F);
      chk({11'h0, o_core1_gain}, exp_reg[7] & 16'h001F);
      if (!i_core2_sel_b) chk({11'h0, o_core2_gain}, exp_reg[8] & 16'h001F);
   endtask : cores_chk

   task automatic summarize();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      int k;
      int i;
      logic [15:0] d;
      void'($urandom(42046));
      for (k = 0; k < 9; k++) begin
         fuse_rom[k] = 16'($urandom);
         exp_reg[k] = fuse_rom[k] & mask_of(k);
      end
      repeat (16) @(posedge i_core_clk);
      i_reset <= 1'b0;
      k = 0;
      while (o_fuse_done !== 1'b1 && k < 100) begin
         @(posedge i_core_clk);
         k++;
      end
      chk({15'h0, o_fuse_done}, 16'h0001);
      for (k = 0; k < 9; k++) rd_chk(reg_addr[k], exp_reg[k]);
      cores_chk();
      for (k = 0; k < 40; k++) begin
         i = int'($urandom_range(8, 0));
         // software keeps reserved bits at zero
         d = 16'($urandom) & ((i < 6) ? 16'h0FFF : 16'h001F);
         if (k < 2) d = (i < 6) ? 16'h0FFF : 16'h001F;
         i_core2_sel_b <= 1'($urandom);
         i_core3_sel_d <= 1'($urandom);
         wr(reg_addr[i], d);
         exp_reg[i] = d;
         rd_chk(reg_addr[i], d);
         cores_chk();
      end
      wr(10'h300, 16'hA5A5);
      rd_chk(10'h300, 16'h0000);
      rd_chk(aogt_pkg::TRIM_STATUS, 16'h0001);
      // an offset read during calibration is flagged, not blocked
      i_offset_cal_busy <= 1'b1;
      rd_chk(reg_addr[4], exp_reg[4]);
      i_offset_cal_busy <= 1'b0;
      rd_chk(aogt_pkg::TRIM_STATUS, 16'h0003);
      wr(aogt_pkg::TRIM_STATUS, 16'h0002);
      rd_chk(aogt_pkg::TRIM_STATUS, 16'h0001);
      for (k = 0; k < 9; k++) rd_chk(reg_addr[k], exp_reg[k]);
      // a reload brings every entry back to its fuse default
      wr(aogt_pkg::TRIM_CONTROL, 16'h0001);
      repeat (3) @(posedge i_core_clk);
      chk({15'h0, o_fuse_done}, 16'h0000);
      k = 0;
      while (o_fuse_done !== 1'b1 && k < 100) begin
         @(posedge i_core_clk);
         k++;
      end
      chk({15'h0, o_fuse_done}, 16'h0001);
      rd_chk(aogt_pkg::TRIM_CONTROL, 16'h0000);
      for (k = 0; k < 9; k++) exp_reg[k] = fuse_rom[k] & mask_of(k);
      for (k = 0; k < 9; k++) rd_chk(reg_addr[k], exp_reg[k]);
      cores_chk();
      summarize();
   end

   initial begin
      repeat (5000) @(posedge i_core_clk);
      error_cnt++;
      summarize();
   end
endmodule : tb_top
